//--- isf_defs.svh
// Address map, field positions and reset values of the spike filter block
`ifndef ISF_DEFS_SVH
`define ISF_DEFS_SVH

// Register addresses on the register port
`define ISF_ADDR_ENABLE_STATUS 32'h5000159C
`define ISF_ADDR_GLITCH_LEN 32'h500015A0
`define ISF_ADDR_COMP_PARAM_LO 32'h500015F4
`define ISF_ADDR_COMP_PARAM_HI 32'h500015F6
`define ISF_ADDR_COMP_VER_LO 32'h500015F8
`define ISF_ADDR_COMP_VER_HI 32'h500015FA
`define ISF_ADDR_COMP_TYPE_LO 32'h500015FC
`define ISF_ADDR_COMP_TYPE_HI 32'h500015FE
`define ISF_ADDR_CTRL_ENABLE 32'h500015E0
`define ISF_ADDR_IRQ_STATUS 32'h500015E4
`define ISF_ADDR_IRQ_MASK 32'h500015E8

// Field positions in the enable, enable status and interrupt registers
`define ISF_BIT_ACTIVE 0
`define ISF_BIT_DIS_BUSY 1
`define ISF_BIT_RX_LOST 2
`define ISF_BIT_ENABLE 0
`define ISF_EVT_W 3

// Reset values and limits
`define ISF_GLITCH_LEN_RESET 8'h01
`define ISF_GLITCH_LEN_MIN 8'h02
`define ISF_WORD_ZERO 16'h0000
`define ISF_SYNC_RESET 2'h3

`endif

//--- isf_filter_if.sv
// Signals between the register side and the glitch filter
`timescale 1ns/1ps
interface isf_filter_if;
  isf_pkg::isf_len_t glitchLength;
  logic [1:0] lineSync;
  logic [1:0] lineFilt;

  modport ctrl (output glitchLength, output lineSync, input lineFilt);
  modport filt (input glitchLength, input lineSync, output lineFilt);
endinterface : isf_filter_if

//--- isf_glitch_filter.sv
// Glitch suppression for the two bus lines
`timescale 1ns/1ps
`include "isf_defs.svh"
module isf_glitch_filter #(
  parameter int LINES = 2,
  parameter int CNT_W = 9
) (
  input wire logic clock,
  input wire logic srst,
  isf_filter_if.filt fif
);

  logic [CNT_W-1:0] stableCnt_r [LINES];
  logic [CNT_W-1:0] stableCnt_nxt [LINES];
  logic [LINES-1:0] filt_r;
  logic [LINES-1:0] filt_nxt;

  // A differing level must persist beyond the length before it passes
  always_comb begin
    for (int i = 0; i < LINES; i++) begin
      filt_nxt[i] = filt_r[i];
      stableCnt_nxt[i] = '0;
      if (fif.lineSync[i] != filt_r[i]) begin
        if (stableCnt_r[i] >= {1'b0, fif.glitchLength}) begin
          filt_nxt[i] = fif.lineSync[i];
        end else begin
          stableCnt_nxt[i] = stableCnt_r[i] + {{(CNT_W-1){1'b0}}, 1'b1};
        end
      end
    end
  end

  // Register the filter state; idle bus lines rest high
  always_ff @(posedge clock) begin
    if (srst) begin
      filt_r <= '1;
      for (int i = 0; i < LINES; i++) begin
        stableCnt_r[i] <= '0;
      end
    end else begin
      filt_r <= filt_nxt;
      for (int i = 0; i < LINES; i++) begin
        stableCnt_r[i] <= stableCnt_nxt[i];
      end
    end
  end

  assign fif.lineFilt = filt_r;

endmodule : isf_glitch_filter

//--- isf_pkg.sv
// Types shared by the spike filter block
package isf_pkg;

  // Activity of the controller as seen on its enable output
  typedef enum logic [1:0] {
    ISF_IDLE = 2'b00,
    ISF_ACTIVE = 2'b01,
    ISF_DRAIN = 2'b10
  } isf_state_t;

  typedef logic [15:0] isf_word_t;
  typedef logic [7:0] isf_len_t;

endpackage : isf_pkg

//--- isf_remote_bus.sv
// Remote bus device that pulls the lines low for chosen spans
`timescale 1ns/1ps
module isf_remote_bus (
  input wire logic clock,
  output logic sclLine,
  output logic sdaLine
);
  // Lines idle high through the pull-ups
  initial begin
    sclLine = 1'b1;
    sdaLine = 1'b1;
  end
  // Pull one line low for a number of edges, then release it
  task automatic pull_low(input bit onScl, input int edges);
    if (onScl) sclLine <= 1'b0;
    else sdaLine <= 1'b0;
    repeat (edges) @(posedge clock);
    sclLine <= 1'b1;
    sdaLine <= 1'b1;
  endtask : pull_low
endmodule : isf_remote_bus

//--- isf_spike_status.sv
// Enable status reporting and spike filter control for the I2C controller
// What this block does
// - Status bit 0 always returns the enable output the block drives.
// - Bit 0 high means enabled; low means fully inactive.
// - Status bit readable any time, reading changes nothing.
// - 8-bit length sets longest removed glitch in clock cycles.
// - Length writes take effect only while the enable setting is 0.
// - Length below 2 only as the reset value 1; smaller writes store 2.
`timescale 1ns/1ps
`include "isf_defs.svh"
module isf_spike_status (
  input wire logic clock,
  input wire logic srst,
  input wire logic [31:0] regAddr,
  input wire logic [15:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [15:0] regRdata,
  input wire logic sclIn,
  input wire logic sdaIn,
  input wire logic ctrlBusy,
  input wire logic rxDataLostEvt,
  input wire logic disabledBusyEvt,
  output logic controllerEnableSetting,
  output logic controllerActiveOutput,
  output logic sclFilt,
  output logic sdaFilt,
  output logic irq
);

  isf_filter_if fif ();

  // Register state
  isf_pkg::isf_state_t state_r;
  isf_pkg::isf_state_t state_nxt;
  logic enable_r;
  logic enable_nxt;
  logic active_r;
  logic active_nxt;
  isf_pkg::isf_len_t glitchLen_r;
  isf_pkg::isf_len_t glitchLen_nxt;
  logic rxLost_r;
  logic rxLost_nxt;
  logic disBusy_r;
  logic disBusy_nxt;
  logic [`ISF_EVT_W-1:0] irqStat_r;
  logic [`ISF_EVT_W-1:0] irqStat_nxt;
  logic [`ISF_EVT_W-1:0] irqMask_r;
  logic [`ISF_EVT_W-1:0] irqMask_nxt;
  isf_pkg::isf_word_t rdata_r;
  isf_pkg::isf_word_t rdata_nxt;

  // Pin synchronisers
  logic [1:0] pinMeta_r;
  logic [1:0] pinSync_r;

  // Decoded strobes
  logic wrEnable;
  logic wrLen;
  logic wrIrqStat;
  logic wrIrqMask;
  logic activeFell;
  logic [`ISF_EVT_W-1:0] events;

  // Clamp a written length to the smallest legal value
  function automatic isf_pkg::isf_len_t clampLen(input isf_pkg::isf_len_t v);
    if (v < `ISF_GLITCH_LEN_MIN) begin
      clampLen = `ISF_GLITCH_LEN_MIN;
    end else begin
      clampLen = v;
    end
  endfunction : clampLen

  // Status word showing the enable output and the two lost flags
  function automatic isf_pkg::isf_word_t statusWord(input logic act,
                                                    input logic busy,
                                                    input logic lost);
    isf_pkg::isf_word_t w;
    w = `ISF_WORD_ZERO;
    w[`ISF_BIT_ACTIVE] = act;
    w[`ISF_BIT_DIS_BUSY] = busy;
    w[`ISF_BIT_RX_LOST] = lost;
    statusWord = w;
  endfunction : statusWord

  // Write address decoding
  always_comb begin
    wrEnable = 1'b0;
    wrLen = 1'b0;
    wrIrqStat = 1'b0;
    wrIrqMask = 1'b0;
    if (!regWrite) begin
      wrEnable = 1'b0;
    end else if (regAddr == `ISF_ADDR_CTRL_ENABLE) begin
      wrEnable = 1'b1;
    end else if (regAddr == `ISF_ADDR_GLITCH_LEN) begin
      wrLen = 1'b1;
    end else if (regAddr == `ISF_ADDR_IRQ_STATUS) begin
      wrIrqStat = 1'b1;
    end else if (regAddr == `ISF_ADDR_IRQ_MASK) begin
      wrIrqMask = 1'b1;
    end
  end

  // Enable setting and the glitch length it guards
  always_comb begin
    enable_nxt = enable_r;
    glitchLen_nxt = glitchLen_r;
    if (wrEnable) begin
      enable_nxt = regWdata[`ISF_BIT_ENABLE];
    end
    if (wrLen && !enable_r) begin
      glitchLen_nxt = clampLen(regWdata[7:0]);
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      enable_r <= 1'b0;
      glitchLen_r <= `ISF_GLITCH_LEN_RESET;
    end else begin
      enable_r <= enable_nxt;
      glitchLen_r <= glitchLen_nxt;
    end
  end

  // Enable output: follows the setting, lingers while a transfer finishes
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      isf_pkg::ISF_IDLE: begin
        if (enable_r) begin
          state_nxt = isf_pkg::ISF_ACTIVE;
        end
      end
      isf_pkg::ISF_ACTIVE: begin
        if (!enable_r && ctrlBusy) begin
          state_nxt = isf_pkg::ISF_DRAIN;
        end else if (!enable_r) begin
          state_nxt = isf_pkg::ISF_IDLE;
        end
      end
      isf_pkg::ISF_DRAIN: begin
        if (enable_r) begin
          state_nxt = isf_pkg::ISF_ACTIVE;
        end else if (!ctrlBusy) begin
          state_nxt = isf_pkg::ISF_IDLE;
        end
      end
      default: begin
        state_nxt = isf_pkg::ISF_IDLE;
      end
    endcase
    active_nxt = (state_nxt != isf_pkg::ISF_IDLE);
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      state_r <= isf_pkg::ISF_IDLE;
      active_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      active_r <= active_nxt;
    end
  end

  assign activeFell = active_r && !active_nxt;

  // Lost-data flags: set by the controller, cleared on a fresh enable
  always_comb begin
    rxLost_nxt = rxLost_r;
    disBusy_nxt = disBusy_r;
    if (!enable_r && enable_nxt) begin
      rxLost_nxt = 1'b0;
      disBusy_nxt = 1'b0;
    end
    if (rxDataLostEvt) begin
      rxLost_nxt = 1'b1;
    end
    if (disabledBusyEvt) begin
      disBusy_nxt = 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      rxLost_r <= 1'b0;
      disBusy_r <= 1'b0;
    end else begin
      rxLost_r <= rxLost_nxt;
      disBusy_r <= disBusy_nxt;
    end
  end

  // Interrupt status: write one to clear, a new event wins over the clear
  always_comb begin
    events = '0;
    events[`ISF_BIT_ACTIVE] = activeFell;
    events[`ISF_BIT_DIS_BUSY] = disabledBusyEvt;
    events[`ISF_BIT_RX_LOST] = rxDataLostEvt;
    irqStat_nxt = irqStat_r;
    irqMask_nxt = irqMask_r;
    if (wrIrqStat) begin
      irqStat_nxt = irqStat_r & ~regWdata[`ISF_EVT_W-1:0];
    end
    irqStat_nxt = irqStat_nxt | events;
    if (wrIrqMask) begin
      irqMask_nxt = regWdata[`ISF_EVT_W-1:0];
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      irqStat_r <= '0;
      irqMask_r <= '0;
    end else begin
      irqStat_r <= irqStat_nxt;
      irqMask_r <= irqMask_nxt;
    end
  end

  // Read data, presented the cycle after the strobe; reads have no effect
  always_comb begin
    rdata_nxt = `ISF_WORD_ZERO;
    if (!regRead) begin
      rdata_nxt = `ISF_WORD_ZERO;
    end else if (regAddr == `ISF_ADDR_ENABLE_STATUS) begin
      rdata_nxt = statusWord(active_r, disBusy_r,
                             rxLost_r);
    end else if (regAddr == `ISF_ADDR_GLITCH_LEN) begin
      rdata_nxt = {8'h00, glitchLen_r};
    end else if (regAddr == `ISF_ADDR_CTRL_ENABLE) begin
      rdata_nxt = {15'h0000, enable_r};
    end else if (regAddr == `ISF_ADDR_IRQ_STATUS) begin
      rdata_nxt = {13'h0000, irqStat_r};
    end else if (regAddr == `ISF_ADDR_IRQ_MASK) begin
      rdata_nxt = {13'h0000, irqMask_r};
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      rdata_r <= `ISF_WORD_ZERO;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  // Two-stage synchronisers on the bus line pins
  always_ff @(posedge clock) begin
    if (srst) begin
      pinMeta_r <= `ISF_SYNC_RESET;
      pinSync_r <= `ISF_SYNC_RESET;
    end else begin
      pinMeta_r <= {sdaIn, sclIn};
      pinSync_r <= pinMeta_r;
    end
  end

  // Filter hookup
  assign fif.glitchLength = glitchLen_r;
  assign fif.lineSync = pinSync_r;

  isf_glitch_filter #(
    .LINES(2),
    .CNT_W(9)
  ) u_filter (
    .clock(clock),
    .srst(srst),
    .fif(fif)
  );

  // Outputs
  assign regRdata = rdata_r;
  assign controllerEnableSetting = enable_r;
  assign controllerActiveOutput = active_r;
  assign sclFilt = fif.lineFilt[0];
  assign sdaFilt = fif.lineFilt[1];
  assign irq = |(irqStat_r & irqMask_r);

endmodule : isf_spike_status

//--- isf_spike_status_bench.sv
// Self-checking bench for the spike filter and enable status block
`timescale 1ns/1ps
`include "isf_defs.svh"
module isf_spike_status_bench;
  logic clock = 1'b0;
  logic srst = 1'b1;
  logic [31:0] regAddr = 32'h00000000;
  logic [15:0] regWdata = 16'h0000;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  logic ctrlBusy = 1'b0;
  logic rxLost = 1'b0;
  logic disBusy = 1'b0;
  logic [15:0] regRdata;
  logic sclIn, sdaIn, enSet, active, sclFilt, sdaFilt, irq;
  int failCount = 0;
  int cmpCount = 0;

  // Clock at 25 ns
  always #12.5 clock = ~clock;

  isf_remote_bus i_far (.clock(clock), .sclLine(sclIn), .sdaLine(sdaIn));
  isf_spike_status i_dut (.clock(clock), .srst(srst), .regAddr(regAddr),
    .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
    .regRdata(regRdata), .sclIn(sclIn), .sdaIn(sdaIn),
    .ctrlBusy(ctrlBusy), .rxDataLostEvt(rxLost),
    .disabledBusyEvt(disBusy), .controllerEnableSetting(enSet),
    .controllerActiveOutput(active), .sclFilt(sclFilt),
    .sdaFilt(sdaFilt), .irq(irq));

  task automatic give_verdict();
    $display("Checks %0d mismatches %0d", cmpCount, failCount);
    if (failCount == 0 && cmpCount > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : give_verdict

  task automatic check(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
    cmpCount++;
    if (seen !== exp) begin
      failCount++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic wr(input logic [31:0] a, input logic [15:0] d);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge clock);
    regWrite <= 1'b0;
    @(posedge clock);
  endtask : wr

  task automatic rdc(input string what, input logic [31:0] a,
                     input logic [15:0] exp);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clock);
    regRead <= 1'b0;
    #1 check(what, regRdata, exp);
    @(posedge clock);
  endtask : rdc

  task automatic evt(input bit lost);
    if (lost) rxLost <= 1'b1;
    else disBusy <= 1'b1;
    @(posedge clock);
    rxLost <= 1'b0;
    disBusy <= 1'b0;
    @(posedge clock);
  endtask : evt

  task automatic t_reset();
    rdc("status", `ISF_ADDR_ENABLE_STATUS, 16'h0000);
    rdc("length", `ISF_ADDR_GLITCH_LEN, 16'h0001);
    rdc("undefined", `ISF_ADDR_COMP_TYPE_HI, 16'h0000);
    rdc("mask", `ISF_ADDR_IRQ_MASK, 16'h0000);
    wr(`ISF_ADDR_ENABLE_STATUS, 16'hFFFF);
    rdc("status ro", `ISF_ADDR_ENABLE_STATUS, 16'h0000);
  endtask : t_reset

  task automatic t_length();
    logic [15:0] wv[5] = '{16'h0000, 16'h0001, 16'h0002, 16'h12FF, 16'h0006};
    logic [15:0] ev[5] = '{16'h0002, 16'h0002, 16'h0002, 16'h00FF, 16'h0006};
    foreach (wv[i]) begin
      wr(`ISF_ADDR_GLITCH_LEN, wv[i]);
      rdc("length", `ISF_ADDR_GLITCH_LEN, ev[i]);
    end
  endtask : t_length

  // Spikes of length 6 vanish, 7 pass; length was set first
  task automatic t_filter();
    logic low;
    for (int l = 0; l < 2; l++) begin
      for (int n = 6; n < 8; n++) begin
        low = 1'b0;
        fork
          i_far.pull_low(l[0], n);
          repeat (n + 16) begin
            @(posedge clock);
            low |= ~(l[0] ? sclFilt : sdaFilt);
          end
        join
        check("spike", {15'h0000, low}, {15'h0000, n > 6});
      end
    end
  endtask : t_filter

  task automatic t_enable();
    ctrlBusy <= 1'b1;
    wr(`ISF_ADDR_CTRL_ENABLE, 16'h0001);
    check("enable out", {15'h0000, enSet}, 16'h0001);
    rdc("active", `ISF_ADDR_ENABLE_STATUS, 16'h0001);
    check("active out", {15'h0000, active}, 16'h0001);
    rdc("active again", `ISF_ADDR_ENABLE_STATUS, 16'h0001);
    wr(`ISF_ADDR_GLITCH_LEN, 16'h0009);
    rdc("locked", `ISF_ADDR_GLITCH_LEN, 16'h0006);
    wr(`ISF_ADDR_CTRL_ENABLE, 16'h0000);
    evt(1'b0);
    rdc("busy hold", `ISF_ADDR_ENABLE_STATUS, 16'h0003);
    ctrlBusy <= 1'b0;
    evt(1'b1);
    rdc("flags", `ISF_ADDR_ENABLE_STATUS, 16'h0006);
    wr(`ISF_ADDR_CTRL_ENABLE, 16'h0001);
    rdc("flags cleared", `ISF_ADDR_ENABLE_STATUS, 16'h0001);
    wr(`ISF_ADDR_CTRL_ENABLE, 16'h0000);
    rdc("inactive", `ISF_ADDR_ENABLE_STATUS, 16'h0000);
  endtask : t_enable

  task automatic t_irq();
    check("irq masked", {15'h0000, irq}, 16'h0000);
    rdc("irq status", `ISF_ADDR_IRQ_STATUS, 16'h0007);
    wr(`ISF_ADDR_IRQ_MASK, 16'h0004);
    check("irq on", {15'h0000, irq}, 16'h0001);
    wr(`ISF_ADDR_IRQ_STATUS, 16'h0004);
    check("irq off", {15'h0000, irq}, 16'h0000);
    rdc("irq left", `ISF_ADDR_IRQ_STATUS, 16'h0003);
    evt(1'b1);
    check("irq again", {15'h0000, irq}, 16'h0001);
    wr(`ISF_ADDR_IRQ_STATUS, 16'h0007);
    rdc("irq clear", `ISF_ADDR_IRQ_STATUS, 16'h0000);
  endtask : t_irq

  // Main sequence
  initial begin
    repeat (3) @(posedge clock);
    srst <= 1'b0;
    @(posedge clock);
    t_reset();
    t_length();
    t_filter();
    t_enable();
    t_irq();
    give_verdict();
  end

  // Watchdog
  initial begin
    repeat (2000) @(posedge clock);
    failCount++;
    give_verdict();
  end
endmodule : isf_spike_status_bench

//--- isf_spike_status_sva.sv
// Port checker for the spike filter and enable status block
`timescale 1ns/1ps
`include "isf_defs.svh"
module isf_spike_status_sva (
  input wire logic clock,
  input wire logic srst,
  input wire logic [31:0] regAddr,
  input wire logic regRead,
  input wire logic regWrite,
  input wire logic [15:0] regRdata,
  input wire logic sdaIn,
  input wire logic ctrlBusy,
  input wire logic controllerEnableSetting,
  input wire logic controllerActiveOutput,
  input wire logic sdaFilt
);
  default clocking @(posedge clock); endclocking
  default disable iff (srst);
  // Read strobes towards the status, length and undefined words
  sequence s_rdStat;
    regRead && regAddr == `ISF_ADDR_ENABLE_STATUS;
  endsequence
  sequence s_rdLen;
    regRead && regAddr == `ISF_ADDR_GLITCH_LEN;
  endsequence
  sequence s_rdRsvd;
    regRead && regAddr >= `ISF_ADDR_COMP_PARAM_LO &&
      regAddr <= `ISF_ADDR_COMP_TYPE_HI;
  endsequence
  sequence s_idle2;
    (!controllerEnableSetting && !ctrlBusy) [*2];
  endsequence
  property p_statBit;
    s_rdStat |=> regRdata[15:3] == 13'h0000 &&
      regRdata[0] == $past(controllerActiveOutput);
  endproperty
  property p_lenHigh;
    s_rdLen |=> regRdata[15:8] == 8'h00 && regRdata[7:0] != 8'h00;
  endproperty
  property p_rsvd;
    s_rdRsvd |=> regRdata == 16'h0000;
  endproperty
  property p_idle;
    !regRead |=> regRdata == 16'h0000;
  endproperty
  property p_actFollow;
    controllerEnableSetting |=> controllerActiveOutput;
  endproperty
  property p_actDrop;
    s_idle2 |=> !controllerActiveOutput;
  endproperty
  property p_actBusy;
    controllerActiveOutput && ctrlBusy |=> controllerActiveOutput;
  endproperty
  property p_enWrite;
    $changed(controllerEnableSetting) |->
      $past(regWrite) && $past(regAddr) == `ISF_ADDR_CTRL_ENABLE;
  endproperty
  property p_sdaPass;
    $changed(sdaFilt) |-> $past(sdaIn, 3) == sdaFilt &&
      $past(sdaIn, 4) == sdaFilt;
  endproperty
  a_statBit: assert property (p_statBit)
    else $error("status word wrong");
  a_lenHigh: assert property (p_lenHigh)
    else $error("length word wrong");
  a_rsvd: assert property (p_rsvd)
    else $error("undefined word not zero");
  a_idle: assert property (p_idle)
    else $error("read data outside its cycle");
  a_actFollow: assert property (p_actFollow)
    else $error("active missing while enabled");
  a_actDrop: assert property (p_actDrop)
    else $error("active stuck after disable");
  a_actBusy: assert property (p_actBusy)
    else $error("active dropped while busy");
  a_enWrite: assert property (p_enWrite)
    else $error("enable changed without write");
  a_sdaPass: assert property (p_sdaPass)
    else $error("data line passed too early");
endmodule : isf_spike_status_sva

bind isf_spike_status isf_spike_status_sva i_sva (.clock(clock),
  .srst(srst), .regAddr(regAddr), .regRead(regRead),
  .regWrite(regWrite), .regRdata(regRdata), .sdaIn(sdaIn),
  .ctrlBusy(ctrlBusy), .controllerEnableSetting(controllerEnableSetting),
  .controllerActiveOutput(controllerActiveOutput), .sdaFilt(sdaFilt));
